// >>> core/ofd_pkg.sv
// package: opcodes, decode types and constants of the octal flash decoder
package ofd_pkg;

    // ==========================================================
    // opcodes
    localparam logic [7:0] OP_RST_EN  = 8'h66;
    localparam logic [7:0] OP_RST_MEM = 8'h99;
    localparam logic [7:0] OP_ID_A    = 8'h9e;
    localparam logic [7:0] OP_ID_B    = 8'h9f;
    localparam logic [7:0] OP_SFDP    = 8'h5a;
    localparam logic [7:0] OP_READ    = 8'h03;
    localparam logic [7:0] OP_FAST    = 8'h0b;
    localparam logic [7:0] OP_OOUT    = 8'h8b;
    localparam logic [7:0] OP_OIO     = 8'hcb;
    localparam logic [7:0] OP_DOUT    = 8'h9d;
    localparam logic [7:0] OP_DIO     = 8'hfd;
    localparam logic [7:0] OP_READ4   = 8'h13;
    localparam logic [7:0] OP_FAST4   = 8'h0c;
    localparam logic [7:0] OP_OOUT4   = 8'h7c;
    localparam logic [7:0] OP_OIO4    = 8'hcc;
    localparam logic [7:0] OP_WR_EN   = 8'h06;
    localparam logic [7:0] OP_WR_DIS  = 8'h04;
    localparam logic [7:0] OP_RD_SR   = 8'h05;
    localparam logic [7:0] OP_RD_FSR  = 8'h70;
    localparam logic [7:0] OP_RD_NVC  = 8'hb5;
    localparam logic [7:0] OP_RD_VC   = 8'h85;
    localparam logic [7:0] OP_RD_PM   = 8'h2b;

    // ==========================================================
    // counts and field positions
    localparam logic [4:0] DMY_0     = 5'h00;
    localparam logic [4:0] DMY_8     = 5'h08;
    localparam logic [4:0] DMY_16    = 5'h10;
    localparam logic [4:0] BIT_LAST  = 5'h07;
    localparam logic [4:0] ID_LAST   = 5'h13;
    localparam logic [4:0] CFG_IDX   = 5'h05;
    localparam int         CFG_BOOT  = 2;
    localparam logic [2:0] ABYTES_3  = 3'h3;
    localparam logic [2:0] ABYTES_4  = 3'h4;
    localparam int         BANK_LSB  = 23;
    localparam logic [1:0] CAP_DONE  = 2'h3;
    localparam logic [7:0] OE_SINGLE = 8'h02;
    localparam logic [7:0] OE_ALL    = 8'hff;

    // ==========================================================
    // types
    typedef enum logic [1:0] {ALEN_0, ALEN_3, ALEN_4, ALEN_MODE} ofd_alen_t;
    typedef enum logic [1:0] {DK_NONE, DK_STREAM, DK_ID, DK_REPEAT} ofd_dkind_t;

    typedef struct packed {
        logic       ok;
        ofd_alen_t  alen;
        logic [4:0] dummy;
        logic       awide;
        logic       dwide;
        logic       array;
        ofd_dkind_t dkind;
    } ofd_dec_t;

    typedef struct packed {
        logic [7:0]  op;
        logic [31:0] addr;
        logic        refused;
    } ofd_cmd_t;

endpackage

// >>> core/ofd_decoder.sv
// command decoder front end of an octal serial nor flash
//
// Notes on behaviour
// - config info byte bit 2 shows boot protocol
// - unknown opcode: standby until select rises
// - valid opcode: active until select rises
// - register write busy refuses array access
// - bank option: read idle banks during busy
// - reset pair 66h/99h, command only
// - id read 9E/9Fh, 0 or 8 dummy
// - sfdp 5Ah: 3 address bytes, 8 dummy
// - read 03h only in extended spi
// - fast read 0Bh: 8 or 16 dummy
// - 8Bh: octal data, 8 or 16 dummy
// - CBh: octal address and data, 16 dummy
// - 9Dh: octal data, 8 or 16 dummy
// - FDh: always four address bytes, 16 dummy
// - 13h/0Ch/7Ch/CCh always four address bytes
// - write enable 06h, disable 04h, command only
// - status read 05h: 0 or 8 dummy
// - flag status read 70h: 0 or 8 dummy
// - nonvolatile config read B5h: 8 dummy
// - volatile config read 85h: 8 dummy
// - protection read 2Bh: 0 or 8 dummy
// - protection read repeats the same byte
`timescale 1ns/1ps
module ofd_decoder #(
    parameter bit           BANK_OPT = 1'b1,
    parameter logic [159:0] ID_VAL   = 160'h0 // arbitrary id content
) (
    input  wire logic            clock,
    input  wire logic            rst_n,
    input  wire logic            clk_en,
    input  wire logic            boot_octal,
    input  wire logic            addr4_mode,
    input  wire logic            reg_wr_busy,
    input  wire logic [3:0]      bank_busy,
    input  wire logic            sclk,
    input  wire logic            cs_n,
    input  wire logic [7:0]      dq_i,
    input  wire logic [7:0]      rd_byte,
    output logic [7:0]           dq_o,
    output logic [7:0]           dq_oe,
    output logic [4:0]           data_idx,
    output logic                 cmd_evt,
    output ofd_pkg::ofd_cmd_t    cmd_info,
    output logic [7:0]           cfg_byte
);
    import ofd_pkg::*;

    typedef enum logic [2:0] {
        ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_DONE, ST_STBY
    } ofd_state_t;

    // ==========================================================
    // opcode table
    function automatic ofd_dec_t dec_op(input logic [7:0] op, input logic oc);
        ofd_dec_t d;
        d = '0;
        d.ok = 1'b1;
        case (op)
            OP_RST_EN, OP_RST_MEM: begin
                d.dkind = DK_NONE;
            end
            OP_WR_EN, OP_WR_DIS: begin
                d.dkind = DK_NONE;
            end
            OP_ID_A, OP_ID_B: begin
                d.dkind = DK_ID;
                d.dummy = oc ? DMY_8 : DMY_0;
            end
            OP_SFDP: begin
                d.alen  = ALEN_3;
                d.dummy = DMY_8;
                d.dkind = DK_STREAM;
            end
            OP_READ, OP_READ4: begin
                d.ok    = !oc;
                d.alen  = (op == OP_READ4) ? ALEN_4 : ALEN_MODE;
                d.array = 1'b1;
                d.dkind = DK_STREAM;
            end
            OP_FAST, OP_FAST4: begin
                d.alen  = (op == OP_FAST4) ? ALEN_4 : ALEN_MODE;
                d.dummy = oc ? DMY_16 : DMY_8;
                d.array = 1'b1;
                d.dkind = DK_STREAM;
            end
            OP_OOUT, OP_OOUT4, OP_DOUT: begin
                d.alen  = (op == OP_OOUT4) ? ALEN_4 : ALEN_MODE;
                d.dummy = oc ? DMY_16 : DMY_8;
                d.dwide = 1'b1;
                d.array = 1'b1;
                d.dkind = DK_STREAM;
            end
            OP_OIO, OP_OIO4, OP_DIO: begin
                d.alen  = (op == OP_OIO) ? ALEN_MODE : ALEN_4;
                d.dummy = DMY_16;
                d.awide = 1'b1;
                d.dwide = 1'b1;
                d.array = 1'b1;
                d.dkind = DK_STREAM;
            end
            OP_RD_SR, OP_RD_FSR: begin
                d.dummy = oc ? DMY_8 : DMY_0;
                d.dkind = DK_STREAM;
            end
            OP_RD_NVC, OP_RD_VC: begin
                d.alen  = ALEN_MODE;
                d.dummy = DMY_8;
                d.dkind = DK_STREAM;
            end
            OP_RD_PM: begin
                d.dummy = oc ? DMY_8 : DMY_0;
                d.dkind = DK_REPEAT;
            end
            default: begin
                d.ok = 1'b0;
            end
        endcase
        return d;
    endfunction

    // ==========================================================
    // system domain: boot strap capture
    logic       boot_m_reg;
    logic       boot_s_reg;
    logic       boot_reg;
    logic [1:0] cap_cnt_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            boot_m_reg <= 1'b0;
            boot_s_reg <= 1'b0;
        end else if (clk_en) begin
            boot_m_reg <= boot_octal;
            boot_s_reg <= boot_m_reg;
        end
    end

    // strap is taken only after the synchroniser has filled
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cap_cnt_reg <= 2'h0;
            boot_reg    <= 1'b0;
            cfg_byte    <= 8'h00;
        end else if (clk_en && cap_cnt_reg != CAP_DONE) begin
            cap_cnt_reg <= cap_cnt_reg + 2'h1;
            boot_reg    <= boot_s_reg;
            cfg_byte    <= 8'h00;
            cfg_byte[CFG_BOOT] <= boot_s_reg;
        end
    end

    // ==========================================================
    // link domain: level synchronisers
    // sclk may stop: a level is seen only two link clocks after it changes
    localparam int LVL_W = 7;
    logic [LVL_W-1:0] lvl_in;
    logic [LVL_W-1:0] lvl_m_reg;
    logic [LVL_W-1:0] lvl_s_reg;

    assign lvl_in = {bank_busy, reg_wr_busy, addr4_mode, boot_reg};

    genvar gi;
    generate
        for (gi = 0; gi < LVL_W; gi++) begin : g_sync
            always_ff @(posedge sclk or negedge rst_n) begin
                if (!rst_n) begin
                    lvl_m_reg[gi] <= 1'b0;
                    lvl_s_reg[gi] <= 1'b0;
                end else begin
                    lvl_m_reg[gi] <= lvl_in[gi];
                    lvl_s_reg[gi] <= lvl_m_reg[gi];
                end
            end
        end
    endgenerate

    logic       oct_s;
    logic       a4_s;
    logic       busy_s;
    logic [3:0] bank_s;
    assign oct_s  = lvl_s_reg[0];
    assign a4_s   = lvl_s_reg[1];
    assign busy_s = lvl_s_reg[2];
    assign bank_s = lvl_s_reg[6:3];

    // ==========================================================
    // link domain: frame state, cleared while select is high
    logic lrst_n;
    assign lrst_n = rst_n & ~cs_n;

    ofd_state_t  state_reg;
    ofd_dec_t    dec_reg;
    logic [7:0]  op_reg;
    logic [7:0]  sh_reg;
    logic [4:0]  cnt_reg;
    logic [2:0]  abytes_reg;
    logic [31:0] addr_reg;
    logic [7:0]  out_reg;

    logic        lanes_c;
    logic        byte_done_c;
    logic [7:0]  in_byte_c;
    ofd_dec_t    dec_c;
    logic        refuse_c;
    logic [31:0] addr_c;
    logic [1:0]  bank_c;
    logic        bank_ref_c;
    logic        last_a_c;
    logic [7:0]  cfg_c;

    always_comb begin
        case (state_reg)
            ST_CMD:  lanes_c = oct_s;
            ST_ADDR: lanes_c = oct_s | dec_reg.awide;
            default: lanes_c = oct_s | dec_reg.dwide;
        endcase
    end

    assign byte_done_c = lanes_c || (cnt_reg == BIT_LAST);
    assign in_byte_c   = lanes_c ? dq_i : {sh_reg[6:0], dq_i[0]};
    assign dec_c       = dec_op(in_byte_c, oct_s);
    assign refuse_c    = !dec_c.ok || (dec_c.array && busy_s);
    assign addr_c      = {addr_reg[23:0], in_byte_c};
    assign bank_c      = addr_c[BANK_LSB+1:BANK_LSB];
    assign last_a_c    = byte_done_c && (abytes_reg == 3'h1);
    // busy bank is always refused; idle banks are refused only without the option
    assign bank_ref_c  = dec_reg.array && (bank_s != 4'h0)
                         && (!BANK_OPT || bank_s[bank_c]);

    always_comb begin
        cfg_c = 8'h00;
        cfg_c[CFG_BOOT] = oct_s;
    end

    function automatic ofd_state_t after_addr(input ofd_dec_t d);
        if (d.dummy != DMY_0) begin
            return ST_DUMMY;
        end else if (d.dkind != DK_NONE) begin
            return ST_DATA;
        end
        return ST_DONE;
    endfunction

    always_ff @(posedge sclk or negedge lrst_n) begin
        if (!lrst_n) begin
            state_reg  <= ST_CMD;
            dec_reg    <= '0;
            op_reg     <= 8'h00;
            sh_reg     <= 8'h00;
            cnt_reg    <= 5'h00;
            abytes_reg <= 3'h0;
            addr_reg   <= 32'h0;
        end else begin
            sh_reg  <= in_byte_c;
            cnt_reg <= byte_done_c ? 5'h00 : cnt_reg + 5'h01;
            case (state_reg)
                ST_CMD: begin
                    if (byte_done_c) begin
                        op_reg  <= in_byte_c;
                        dec_reg <= dec_c;
                        if (refuse_c) begin
                            state_reg <= ST_STBY;
                        end else if (dec_c.alen == ALEN_0) begin
                            state_reg <= after_addr(dec_c);
                        end else begin
                            state_reg <= ST_ADDR;
                        end
                        case (dec_c.alen)
                            ALEN_3:    abytes_reg <= ABYTES_3;
                            ALEN_4:    abytes_reg <= ABYTES_4;
                            ALEN_MODE: abytes_reg <= a4_s ? ABYTES_4 : ABYTES_3;
                            default:   abytes_reg <= 3'h0;
                        endcase
                    end
                end
                ST_ADDR: begin
                    if (byte_done_c) begin
                        addr_reg   <= addr_c;
                        abytes_reg <= abytes_reg - 3'h1;
                        if (last_a_c) begin
                            state_reg <= bank_ref_c ? ST_STBY : after_addr(dec_reg);
                        end
                    end
                end
                ST_DUMMY: begin
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == dec_reg.dummy - 5'h01) begin
                        cnt_reg   <= 5'h00;
                        state_reg <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (byte_done_c && dec_reg.dkind == DK_ID && data_idx == ID_LAST) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: state_reg <= ST_DONE;
                ST_STBY: state_reg <= ST_STBY;
                default: state_reg <= ST_STBY;
            endcase
        end
    end

    // ==========================================================
    // link domain: data output
    logic       load_c;
    logic [7:0] src_c;
    logic [7:0] cur_c;
    logic [2:0] bit_c;

    assign load_c = (state_reg == ST_DATA) && (lanes_c || cnt_reg == 5'h00);
    assign bit_c  = 3'h7 - cnt_reg[2:0];

    always_comb begin
        case (dec_reg.dkind)
            DK_ID: begin
                src_c = (data_idx == CFG_IDX) ? cfg_c
                        : ID_VAL[159 - 8*data_idx -: 8];
            end
            default: src_c = rd_byte;
        endcase
    end

    assign cur_c = load_c ? src_c : out_reg;

    always_ff @(posedge sclk or negedge lrst_n) begin
        if (!lrst_n) begin
            out_reg  <= 8'h00;
            dq_o     <= 8'h00;
            dq_oe    <= 8'h00;
            data_idx <= 5'h00;
        end else if (state_reg == ST_DATA) begin
            out_reg <= cur_c;
            dq_o    <= lanes_c ? cur_c : {6'h00, cur_c[bit_c], 1'b0};
            dq_oe   <= lanes_c ? OE_ALL : OE_SINGLE;
            // the protection byte never advances; others run on
            if (byte_done_c && dec_reg.dkind != DK_REPEAT) begin
                data_idx <= data_idx + 5'h01;
            end
        end else begin
            dq_o  <= 8'h00;
            dq_oe <= 8'h00;
        end
    end

    // ==========================================================
    // command report to the system clock (toggle handshake)
    // hold/toggle survive select so a frame end never fakes an event;
    // two reports with no system clock between them cancel and give no event
    ofd_cmd_t hold_reg;
    logic     tog_reg;
    logic     rep_c;
    logic     rep_ref_c;

    assign rep_c = (state_reg == ST_CMD && byte_done_c && (refuse_c
                    || dec_c.alen == ALEN_0))
                   || (state_reg == ST_ADDR && last_a_c);
    assign rep_ref_c = (state_reg == ST_CMD) ? refuse_c : bank_ref_c;

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= '0;
            tog_reg  <= 1'b0;
        end else if (!cs_n && rep_c) begin
            hold_reg.op      <= (state_reg == ST_CMD) ? in_byte_c : op_reg;
            hold_reg.addr    <= (state_reg == ST_CMD) ? 32'h0 : addr_c;
            hold_reg.refused <= rep_ref_c;
            tog_reg          <= ~tog_reg;
        end
    end

    logic tog_m_reg;
    logic tog_s_reg;
    logic tog_d_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tog_m_reg <= 1'b0;
            tog_s_reg <= 1'b0;
            tog_d_reg <= 1'b0;
            cmd_evt   <= 1'b0;
            cmd_info  <= '0;
        end else if (clk_en) begin
            tog_m_reg <= tog_reg;
            tog_s_reg <= tog_m_reg;
            tog_d_reg <= tog_s_reg;
            cmd_evt   <= tog_s_reg ^ tog_d_reg;
            if (tog_s_reg ^ tog_d_reg) begin
                cmd_info <= hold_reg;
            end
        end
    end

    // ==========================================================
    // checks
    logic cmd_end_c;
    assign cmd_end_c = (state_reg == ST_CMD) && byte_done_c;

    sequence dmy16_entry_s;
        state_reg != ST_DUMMY ##1 state_reg == ST_DUMMY && dec_reg.dummy == DMY_16;
    endsequence

    sequence addr_entry_s;
        state_reg == ST_CMD ##1 state_reg == ST_ADDR;
    endsequence

    bad_opcode_a: assert property (@(posedge sclk) disable iff (!lrst_n)
        cmd_end_c && !dec_c.ok |=> state_reg == ST_STBY)
        else $error("unknown opcode did not enter standby");

    standby_hold_a: assert property (@(posedge sclk) disable iff (!lrst_n)
        state_reg == ST_STBY |=> state_reg == ST_STBY && dq_oe == 8'h00)
        else $error("standby left within the frame");

    good_opcode_a: assert property (@(posedge sclk) disable iff (!lrst_n)
        cmd_end_c && !refuse_c |=> state_reg != ST_STBY && state_reg != ST_CMD)
        else $error("valid opcode not made active");

    array_block_a: assert property (@(posedge sclk) disable iff (!lrst_n)
        cmd_end_c && dec_c.array && busy_s |=> state_reg == ST_STBY)
        else $error("array access during register write");

    plain_read_a: assert property (@(posedge sclk) disable iff (!lrst_n)
        cmd_end_c && in_byte_c == OP_READ && oct_s |=> state_reg == ST_STBY)
        else $error("plain read accepted in octal mode");

    dummy_sixteen_a: assert property (@(posedge sclk) disable iff (!lrst_n)
        dmy16_entry_s |-> ##15 state_reg == ST_DUMMY ##1 state_reg == ST_DATA)
        else $error("sixteen dummy cycles miscounted");

    four_byte_a: assert property (@(posedge sclk) disable iff (!lrst_n)
        addr_entry_s ##0 dec_reg.alen == ALEN_4 |-> abytes_reg == ABYTES_4)
        else $error("four byte command without four address bytes");

    addr_mode_a: assert property (@(posedge sclk) disable iff (!lrst_n)
        addr_entry_s ##0 dec_reg.alen == ALEN_MODE
        |-> abytes_reg == (a4_s ? ABYTES_4 : ABYTES_3))
        else $error("address length ignores address mode");

    pm_repeat_a: assert property (@(posedge sclk) disable iff (!lrst_n)
        state_reg == ST_DATA && dec_reg.dkind == DK_REPEAT |-> data_idx == 5'h00)
        else $error("protection byte index advanced");

    stream_step_a: assert property (@(posedge sclk) disable iff (!lrst_n)
        state_reg == ST_DATA && dec_reg.dkind == DK_STREAM && byte_done_c
        |=> data_idx == $past(data_idx) + 5'h01)
        else $error("stream index did not advance");

    cfg_bit_a: assert property (@(posedge sclk) disable iff (!lrst_n)
        load_c && dec_reg.dkind == DK_ID && data_idx == CFG_IDX
        |=> out_reg[CFG_BOOT] == oct_s)
        else $error("config byte lost boot protocol");

endmodule

// >>> sim/ofd_host_model.sv
// host side model: select, link clock and data lines, samples the answers
`timescale 1ns/1ps
module ofd_host_model (
    output logic            sclk,
    output logic            cs_n,
    output logic [7:0]      dq_i,
    input  wire logic [7:0] dq_o,
    input  wire logic [7:0] dq_oe
);
    logic [7:0] cap    [0:31];
    logic [7:0] oe_cap [0:31];
    // link clock stands still between frames, apart from two lead-in clocks
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        dq_i = 8'h00;
    end
    // ==========================================================
    // one link clock, answer sampled late in the high phase
    task automatic cyc(input logic [7:0] d, output logic [7:0] o, output logic [7:0] e);
        dq_i = d;
        #6 sclk = 1'b1;
        #5 o = dq_o;
        e = dq_oe;
        #1 sclk = 1'b0;
    endtask
    // one byte: eight clocks on line 0, msb first, or one clock on all lines
    task automatic xfer(input logic [7:0] d, input bit wide, output logic [7:0] o,
                        output logic [7:0] e);
        logic [7:0] b;
        if (wide) begin
            cyc(d, o, e);
        end else begin
            for (int i = 7; i >= 0; i--) begin
                cyc({~dq_i[7:1], d[i]}, b, e);
                o[i] = b[1];
            end
        end
    endtask
    // ==========================================================
    // one whole frame, one command per select low
    task automatic frame(input logic [7:0] op, input logic [31:0] a, input int nab,
                         input int ndm, input int ndat, input bit oct, input bit aw,
                         input bit dw);
        logic [7:0] o;
        logic [7:0] e;
        // levels cross to the link side only on link clocks: two before select
        repeat (2) begin
            #6 sclk = 1'b1;
            #6 sclk = 1'b0;
        end
        cs_n = 1'b0;
        #6;
        xfer(op, oct, o, e);
        for (int j = nab - 1; j >= 0; j--) xfer(a[8*j +: 8], oct | aw, o, e);
        // released lines toggle so a stale value never looks valid
        for (int j = 0; j < ndm; j++) cyc(~dq_i, o, e);
        for (int k = 0; k < ndat; k++) xfer(~dq_i, oct | dw, cap[k], oe_cap[k]);
        #6 cs_n = 1'b1;
        dq_i = ~dq_i;
    endtask
endmodule

// >>> sim/ofd_decoder_test.sv
// testbench of the octal flash command decoder
`timescale 1ns/1ps
module ofd_decoder_test;
    import ofd_pkg::*;
    logic       clock       = 1'b0;
    logic       rst_n       = 1'b0;
    logic       boot_octal  = 1'b0;
    logic       addr4_mode  = 1'b0;
    logic       reg_wr_busy = 1'b0;
    logic [3:0] bank_busy   = 4'h0;
    logic       sclk, cs_n, cmd_evt;
    logic [7:0] dq_i, dq_o, dq_oe, rd_byte, cfg_byte;
    logic [4:0] data_idx;
    ofd_cmd_t   cmd_info, last_cmd;
    int         mismatches = 0;
    int         cmp_count  = 0;
    int         evt_cnt    = 0;
    always #10 clock = ~clock;
    // slot content follows the index, so a stuck index shows
    assign rd_byte = 8'hc3 ^ {3'h0, data_idx};
    always @(posedge clock) begin
        if (cmd_evt === 1'b1) begin
            last_cmd <= cmd_info;
            evt_cnt  <= evt_cnt + 1;
        end
    end
    ofd_decoder #(.BANK_OPT(1'b1), .ID_VAL(160'h0)) dut_u (
        .clock(clock), .rst_n(rst_n), .clk_en(1'b1), .boot_octal(boot_octal),
        .addr4_mode(addr4_mode), .reg_wr_busy(reg_wr_busy), .bank_busy(bank_busy),
        .sclk(sclk), .cs_n(cs_n), .dq_i(dq_i), .rd_byte(rd_byte), .dq_o(dq_o),
        .dq_oe(dq_oe), .data_idx(data_idx), .cmd_evt(cmd_evt), .cmd_info(cmd_info),
        .cfg_byte(cfg_byte));
    ofd_host_model host_u (.sclk(sclk), .cs_n(cs_n), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
    // ==========================================================
    // compares and closing
    task automatic chk8(input string nm, input logic [7:0] ex, input logic [7:0] got);
        cmp_count++;
        if (got !== ex) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic chk32(input string nm, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // shared steps
    task automatic do_reset(input logic boot);
        @(negedge clock);
        rst_n = 1'b0;
        boot_octal = boot;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        repeat (8) @(negedge clock);
        chk8("config", {5'h0, boot, 2'h0}, cfg_byte);
    endtask
    task automatic rd(input logic [7:0] op, input logic [31:0] a, input int nab,
                      input int ndm, input int ndat, input bit aw, input bit dw,
                      input bit ok, input bit rep);
        int n0;
        n0 = evt_cnt;
        host_u.frame(op, a, nab, ndm, ndat, boot_octal, aw, dw);
        repeat (8) @(negedge clock);
        for (int k = 0; k < ndat; k++) begin
            if (ok) chk8("data", 8'hc3 ^ (rep ? 8'h00 : 8'(k)), host_u.cap[k]);
            chk8("enable", ok ? ((boot_octal | dw) ? OE_ALL : OE_SINGLE) : 8'h00,
                 host_u.oe_cap[k]);
        end
        chk8("events", 8'h01, 8'(evt_cnt - n0));
        chk8("opcode", op, last_cmd.op);
        if (nab > 0) chk32("address", (ok || !reg_wr_busy) ? a : 32'h0, last_cmd.addr);
        chk8("refused", {7'h0, ~ok}, {7'h0, last_cmd.refused});
    endtask
    task automatic t_id(input logic [7:0] op, input int ndm);
        host_u.frame(op, 32'h0, 0, ndm, 20, boot_octal, 1'b0, 1'b0);
        for (int k = 0; k < 20; k++)
            chk8("id", (k == int'(CFG_IDX)) ? {5'h0, boot_octal, 2'h0} : 8'h00,
                 host_u.cap[k]);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_ext_reads;
        rd(OP_READ, 32'h00123456, 3, 0, 3, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(OP_FAST, 32'h00abcdef, 3, 8, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(OP_OOUT, 32'h00010203, 3, 8, 3, 1'b0, 1'b1, 1'b1, 1'b0);
        rd(OP_OIO, 32'h00405060, 3, 16, 3, 1'b1, 1'b1, 1'b1, 1'b0);
        rd(OP_DOUT, 32'h00070809, 3, 8, 3, 1'b0, 1'b1, 1'b1, 1'b0);
        rd(OP_DIO, 32'h01020304, 4, 16, 2, 1'b1, 1'b1, 1'b1, 1'b0);
        rd(OP_READ4, 32'h0a0b0c0d, 4, 0, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(OP_FAST4, 32'h11223344, 4, 8, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(OP_OOUT4, 32'h00000011, 4, 8, 2, 1'b0, 1'b1, 1'b1, 1'b0);
        rd(OP_OIO4, 32'h00fedcba, 4, 16, 2, 1'b1, 1'b1, 1'b1, 1'b0);
    endtask
    task automatic t_ext_regs;
        rd(OP_RD_SR, 32'h0, 0, 0, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(OP_RD_FSR, 32'h0, 0, 0, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(OP_RD_NVC, 32'h00000100, 3, 8, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(OP_RD_VC, 32'h00000200, 3, 8, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(OP_RD_PM, 32'h0, 0, 0, 3, 1'b0, 1'b0, 1'b1, 1'b1);
        rd(OP_SFDP, 32'h00000030, 3, 8, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        t_id(OP_ID_A, 0);
        t_id(OP_ID_B, 0);
        rd(OP_RST_EN, 32'h0, 0, 0, 0, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(OP_RST_MEM, 32'h0, 0, 0, 0, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(OP_WR_EN, 32'h0, 0, 0, 0, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(OP_WR_DIS, 32'h0, 0, 0, 0, 1'b0, 1'b0, 1'b1, 1'b0);
    endtask
    task automatic t_mode4;
        addr4_mode = 1'b1;
        rd(OP_FAST, 32'h12345678, 4, 8, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(OP_RD_VC, 32'h00000204, 4, 8, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(OP_SFDP, 32'h00000102, 3, 8, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        addr4_mode = 1'b0;
    endtask
    task automatic t_refuse;
        host_u.frame(8'h11, 32'h0, 0, 0, 2, boot_octal, 1'b0, 1'b0);
        chk8("standby", 8'h00, host_u.oe_cap[1]);
        rd(OP_FAST, 32'h00000040, 3, 8, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        reg_wr_busy = 1'b1;
        repeat (4) @(negedge clock);
        rd(OP_FAST, 32'h00000080, 3, 8, 2, 1'b0, 1'b0, 1'b0, 1'b0);
        rd(OP_RD_SR, 32'h0, 0, 0, 1, 1'b0, 1'b0, 1'b1, 1'b0);
        reg_wr_busy = 1'b0;
    endtask
    task automatic t_banks;
        bank_busy = 4'h1;
        repeat (4) @(negedge clock);
        rd(OP_FAST4, 32'h00800000, 4, 8, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(OP_FAST4, 32'h00000010, 4, 8, 2, 1'b0, 1'b0, 1'b0, 1'b0);
        bank_busy = 4'h0;
    endtask
    task automatic t_octal;
        do_reset(1'b1);
        rd(OP_RD_SR, 32'h0, 0, 8, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        t_id(OP_ID_B, 8);
        rd(OP_FAST, 32'h00aabbcc, 3, 16, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(OP_RD_PM, 32'h0, 0, 8, 2, 1'b0, 1'b0, 1'b1, 1'b1);
        rd(OP_SFDP, 32'h00000008, 3, 8, 2, 1'b0, 1'b0, 1'b1, 1'b0);
        host_u.frame(OP_READ, 32'h0, 3, 0, 2, 1'b1, 1'b0, 1'b0);
        chk8("enable", 8'h00, host_u.oe_cap[0]);
    endtask
    // ==========================================================
    // watchdog, far beyond the expected run length
    initial begin
        #500000;
        mismatches++;
        finish_test();
    end
    initial begin
        do_reset(1'b0);
        t_ext_reads();
        t_ext_regs();
        t_mode4();
        t_refuse();
        t_banks();
        t_octal();
        finish_test();
    end
endmodule
